/* File: core/cle_pkg.sv */
// Constants shared by the character display instruction executor
// What this block does
// - screen_on high shows the display; low blanks it, display RAM kept.
// - pointer_visible shows the cursor; clearing hides it, step_direction kept.
// - flash_toggle alternates cursor cell between all dots on and the character.
// - Instruction 0001 with target bit 3, direction bit 2 moves cursor or display.
// - 00 cursor left, 01 cursor right, 10 display left, 11 display right.
// - Display shift keeps address_counter and moves all lines together.
// - Two-line cursor past 40th position of line one continues on line two.
// - bus_width high selects 8-bit bus; low 4-bit with two transfers per byte.
// - two_row low selects one-line mode, high two-line mode.
// - glyph_height low selects 5x8 dots, high 5x11 dots.
// - Character-generator address set loads 6-bit address, selects char_gen_ram.
// - Display address set loads 7-bit address, selects display_data_ram.
// - One-line spans 00H-4FH; two-line 00H-27H and 40H-67H.
// - Status read returns busy_flag on bit 7, address_counter on bits 6..0.
// - Data write stores a byte in the RAM chosen by last address set.
// - Each RAM data access steps address_counter by one per entry direction.
// - First read without prior address set is invalid; host sets address first.
// - Cursor shift reloads the output data register from display RAM.
// - After a write, a read returns the previously latched output register.
// - Positions 1-16 map to 00-0F on line one, 40-4F on line two.
// - step_direction high moves right and increments; low moves left, decrements.
package cle_pkg;
    // ***************************************************************
    // Timing
    // ***************************************************************
    localparam int CLK_NS = 40;
    localparam int EXEC_NS = 39000;
    localparam int DATA_NS = 43000;
    localparam int BLINK_HALF_NS = 400000000;
    localparam logic [10:0] EXEC_CYC = 11'((EXEC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [10:0] DATA_CYC = 11'((DATA_NS + CLK_NS - 1) / CLK_NS);
    // ***************************************************************
    // Display RAM map
    // ***************************************************************
    localparam logic [6:0] DD_FIRST = 7'h00;
    localparam logic [6:0] DD1_LAST = 7'h4F;
    localparam logic [6:0] DD2_L1_LAST = 7'h27;
    localparam logic [6:0] DD2_L2_FIRST = 7'h40;
    localparam logic [6:0] DD2_L2_LAST = 7'h67;
    localparam logic [6:0] LINE1_LEN = 7'h50;
    localparam logic [6:0] LINE2_LEN = 7'h28;
    // ***************************************************************
    // Instruction patterns
    // ***************************************************************
    localparam logic [1:0] OP_SET_CG = 2'h1;
    localparam logic [2:0] OP_FUNC = 3'h1;
    localparam logic [3:0] OP_SHIFT = 4'h1;
    localparam logic [4:0] OP_DISP = 5'h01;
    localparam logic [5:0] OP_ENTRY = 6'h01;
    // ***************************************************************
    // Register map and fields
    // ***************************************************************
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_SCAN = 8'h04;
    localparam logic [7:0] OFS_VIEW = 8'h08;
    localparam int ST_BUSY = 7;
    localparam int ST_SEL_CG = 8;
    localparam int ST_SCREEN = 9;
    localparam int ST_POINTER = 10;
    localparam int ST_FLASH = 11;
    localparam int ST_STEP = 12;
    localparam int ST_SCROLL = 13;
    localparam int ST_BUS_WIDTH = 14;
    localparam int ST_TWO_ROW = 15;
    localparam int ST_GLYPH_H = 16;
    localparam int ST_SHIFT_LSB = 17;
    localparam int SCAN_ROW = 4;
    localparam int VIEW_CURSOR = 8;
    localparam logic [4:0] RST_SCAN = 5'h00;
    localparam logic RST_BUS_WIDTH = 1'b1;
    localparam logic RST_STEP_DIR = 1'b1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [7:0] ALL_DOTS = 8'hFF;
endpackage

/* File: core/cle_exec.sv */
// Instruction executor of the character display controller
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
module cle_exec
    import cle_pkg::*;
#(
    parameter int unsigned BLINK_HALF_CYC = BLINK_HALF_NS / CLK_NS
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_arst_n,
    // Host parallel port
    input wire logic i_register_select,
    input wire logic i_read_write,
    input wire logic i_enable,
    input wire logic [7:0] i_db,
    output logic [7:0] o_db,
    output logic o_db_oe,
    // AXI4-Lite write channels
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // AXI4-Lite read channels
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp
);
    // ***************************************************************
    // State
    // ***************************************************************
    logic [7:0] disp_mem [0:127];
    logic [7:0] glyph_mem [0:63];
    logic e_q;
    logic nib_second;
    logic [3:0] nib_buf;
    logic [6:0] addr_cnt;
    logic sel_cg;
    logic [6:0] ofs;
    logic [7:0] dout;
    logic pend_load;
    logic [10:0] busy_cnt;
    logic screen_on, pointer_visible, flash_toggle;
    logic step_dir, scroll_on_write;
    logic bus_width, two_row, glyph_height;
    logic [23:0] blink_cnt;
    logic blink_phase;
    logic [4:0] scan;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    // Step the address counter, wrapping inside the active RAM window
    function automatic logic [6:0] addr_step(input logic [6:0] a, input logic up,
                                             input logic cg, input logic two);
        logic [6:0] r;
        r = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
        if (cg) begin
            r = {1'b0, r[5:0]};
        end else if (two) begin
            if (up && a == DD2_L1_LAST) begin
                r = DD2_L2_FIRST;
            end else if (up && a == DD2_L2_LAST) begin
                r = DD_FIRST;
            end else if (!up && a == DD_FIRST) begin
                r = DD2_L2_LAST;
            end else if (!up && a == DD2_L2_FIRST) begin
                r = DD2_L1_LAST;
            end
        end else if (up && a == DD1_LAST) begin
            r = DD_FIRST;
        end else if (!up && a == DD_FIRST) begin
            r = DD1_LAST;
        end
        return r;
    endfunction

    // ***************************************************************
    // Host strobe and nibble pairing
    // ***************************************************************
    // Transfers complete on the falling strobe edge
    wire e_fall = e_q & ~i_enable;
    wire byte_done = e_fall & (bus_width | nib_second);
    wire [7:0] wbyte = bus_width ? i_db : {nib_buf, i_db[7:4]};
    wire do_cmd = byte_done & ~i_register_select & ~i_read_write;
    wire do_wr = byte_done & i_register_select & ~i_read_write;
    wire do_rd = byte_done & i_register_select & i_read_write;

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            e_q <= 1'b0;
            nib_second <= 1'b0;
            nib_buf <= 4'h0;
        end else begin
            e_q <= i_enable;
            // Upper nibble first, then lower
            if (bus_width) begin
                nib_second <= 1'b0;
            end else if (e_fall) begin
                nib_second <= ~nib_second;
            end
            if (e_fall && !nib_second) begin
                nib_buf <= i_db[7:4];
            end
        end
    end

    // ***************************************************************
    // Instruction decode
    // ***************************************************************
    wire is_setdd = do_cmd & wbyte[7];
    wire is_setcg = do_cmd & (wbyte[7:6] == OP_SET_CG);
    wire is_func = do_cmd & (wbyte[7:5] == OP_FUNC);
    wire is_shift = do_cmd & (wbyte[7:4] == OP_SHIFT);
    wire is_disp = do_cmd & (wbyte[7:3] == OP_DISP);
    wire is_entry = do_cmd & (wbyte[7:2] == OP_ENTRY);
    wire cur_shift = is_shift & ~wbyte[3];
    wire disp_shift = is_shift & wbyte[3];
    wire scroll_wr = do_wr & scroll_on_write & ~sel_cg;

    // ***************************************************************
    // Address counter and display shift
    // ***************************************************************
    wire [6:0] addr_up = addr_step(addr_cnt, 1'b1, sel_cg, two_row);
    wire [6:0] addr_dn = addr_step(addr_cnt, 1'b0, sel_cg, two_row);
    wire [6:0] line_len = two_row ? LINE2_LEN : LINE1_LEN;
    wire [6:0] ofs_up = (7'(ofs + 7'h01) >= line_len) ? DD_FIRST : 7'(ofs + 7'h01);
    wire [6:0] ofs_dn = (ofs == DD_FIRST) ? 7'(line_len - 7'h01) : 7'(ofs - 7'h01);
    // Address set wins, then cursor moves, then data access steps
    wire [6:0] next_addr_cnt = is_setdd ? wbyte[6:0] :
                               is_setcg ? {1'b0, wbyte[5:0]} :
                               cur_shift ? (wbyte[2] ? addr_up : addr_dn) :
                               (do_wr | do_rd) ? (step_dir ? addr_up : addr_dn) : addr_cnt;
    // Left display shift raises the offset; one offset serves every line
    wire [6:0] next_ofs = disp_shift ? (wbyte[2] ? ofs_dn : ofs_up) :
                          scroll_wr ? (step_dir ? ofs_up : ofs_dn) : ofs;

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            addr_cnt <= DD_FIRST;
            ofs <= DD_FIRST;
            sel_cg <= 1'b0;
        end else begin
            addr_cnt <= next_addr_cnt;
            ofs <= next_ofs;
            if (is_setdd | is_setcg) begin
                sel_cg <= is_setcg;
            end
        end
    end

    // ***************************************************************
    // Control flags
    // ***************************************************************
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            screen_on <= 1'b0;
            pointer_visible <= 1'b0;
            flash_toggle <= 1'b0;
            step_dir <= RST_STEP_DIR;
            scroll_on_write <= 1'b0;
            bus_width <= RST_BUS_WIDTH;
            two_row <= 1'b0;
            glyph_height <= 1'b0;
        end else begin
            if (is_disp) begin
                screen_on <= wbyte[2];
                pointer_visible <= wbyte[1];
                flash_toggle <= wbyte[0];
            end
            if (is_entry) begin
                step_dir <= wbyte[1];
                scroll_on_write <= wbyte[0];
            end
            if (is_func) begin
                bus_width <= wbyte[4];
                two_row <= wbyte[3];
                glyph_height <= wbyte[2];
            end
        end
    end

    // ***************************************************************
    // RAM and output data register
    // ***************************************************************
    // Storage has no reset; contents survive display off
    always_ff @(posedge i_mclk) begin
        if (do_wr && sel_cg) begin
            glyph_mem[addr_cnt[5:0]] <= wbyte;
        end
        if (do_wr && !sel_cg) begin
            disp_mem[addr_cnt] <= wbyte;
        end
    end

    // Reload one cycle later, from the already updated counter
    wire load_req = is_setdd | is_setcg | (cur_shift & ~sel_cg) | do_rd;
    wire [7:0] ram_at_addr = sel_cg ? glyph_mem[addr_cnt[5:0]] : disp_mem[addr_cnt];

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pend_load <= 1'b0;
            dout <= 8'h00;
        end else begin
            pend_load <= load_req;
            // Writes never refresh it, so reads return stale data
            if (pend_load) begin
                dout <= ram_at_addr;
            end
        end
    end

    // ***************************************************************
    // Busy timer and host read drive
    // ***************************************************************
    wire busy_flag = busy_cnt != 11'h000;
    wire [7:0] rd_byte = i_register_select ? dout : {busy_flag, addr_cnt};
    wire [7:0] rd_out = bus_width ? rd_byte :
                        {(nib_second ? rd_byte[3:0] : rd_byte[7:4]), 4'h0};
    wire [10:0] next_busy = do_cmd ? EXEC_CYC :
                            (do_wr | do_rd) ? DATA_CYC :
                            busy_flag ? 11'(busy_cnt - 11'h001) : busy_cnt;

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            busy_cnt <= 11'h000;
            o_db <= 8'h00;
            o_db_oe <= 1'b0;
        end else begin
            busy_cnt <= next_busy;
            o_db <= (i_enable & i_read_write) ? rd_out : 8'h00;
            o_db_oe <= i_enable & i_read_write;
        end
    end

    // ***************************************************************
    // Blink phase and rendered view
    // ***************************************************************
    wire blink_wrap = blink_cnt == 24'(BLINK_HALF_CYC - 1);

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            blink_cnt <= 24'h000000;
            blink_phase <= 1'b0;
        end else begin
            blink_cnt <= blink_wrap ? 24'h000000 : 24'(blink_cnt + 24'h000001);
            if (blink_wrap) begin
                blink_phase <= ~blink_phase;
            end
        end
    end

    // Scan position to display address, with shift applied
    wire scan_row = scan[SCAN_ROW];
    wire [6:0] col_sum = {3'h0, scan[3:0]} + ofs;
    wire [6:0] col_wrap = (col_sum >= line_len) ? 7'(col_sum - line_len) : col_sum;
    wire [6:0] scan_addr = (two_row & scan_row) ? 7'(col_wrap + DD2_L2_FIRST) : col_wrap;
    wire row_ok = two_row | ~scan_row;
    wire cursor_here = ~sel_cg & (addr_cnt == scan_addr);
    wire lit = screen_on & row_ok;
    wire [7:0] view_glyph = !lit ? 8'h00 :
                            (flash_toggle & cursor_here & blink_phase) ? ALL_DOTS :
                            disp_mem[scan_addr];
    wire view_cursor = lit & pointer_visible & cursor_here;

    // ***************************************************************
    // AXI4-Lite slave
    // ***************************************************************
    logic [31:0] status_word;
    always_comb begin
        status_word = 32'h00000000;
        status_word[6:0] = addr_cnt;
        status_word[ST_BUSY] = busy_flag;
        status_word[ST_SEL_CG] = sel_cg;
        status_word[ST_SCREEN] = screen_on;
        status_word[ST_POINTER] = pointer_visible;
        status_word[ST_FLASH] = flash_toggle;
        status_word[ST_STEP] = step_dir;
        status_word[ST_SCROLL] = scroll_on_write;
        status_word[ST_BUS_WIDTH] = bus_width;
        status_word[ST_TWO_ROW] = two_row;
        status_word[ST_GLYPH_H] = glyph_height;
        status_word[ST_SHIFT_LSB +: 7] = ofs;
    end

    // Read decode; unmapped addresses answer SLVERR with zero data
    wire rd_map = (i_araddr == OFS_STATUS) | (i_araddr == OFS_SCAN) | (i_araddr == OFS_VIEW);
    wire [31:0] rd_word = (i_araddr == OFS_STATUS) ? status_word :
                          (i_araddr == OFS_SCAN) ? {27'h0000000, scan} :
                          (i_araddr == OFS_VIEW) ? {23'h000000, view_cursor, view_glyph} :
                          32'h00000000;
    wire ar_take = i_arvalid & o_arready;
    wire aw_take = i_awvalid & o_awready;
    wire w_take = i_wvalid & o_wready;
    // Address and data may arrive in either order; fire once both are held
    wire wr_fire = ~o_awready & ~o_wready & ~o_bvalid;
    wire wr_scan = awaddr_q == OFS_SCAN;
    wire wr_map = (awaddr_q == OFS_STATUS) | wr_scan | (awaddr_q == OFS_VIEW);

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            scan <= RST_SCAN;
        end else begin
            if (aw_take) begin
                o_awready <= 1'b0;
                awaddr_q <= i_awaddr;
            end
            if (w_take) begin
                o_wready <= 1'b0;
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
            end
            if (wr_fire) begin
                o_bvalid <= 1'b1;
                o_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
                if (wr_scan && wstrb_q[0]) begin
                    scan <= wdata_q[4:0];
                end
            end
            if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
                o_awready <= 1'b1;
                o_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_arready <= 1'b1;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h00000000;
            o_rresp <= RESP_OKAY;
        end else begin
            if (ar_take) begin
                o_arready <= 1'b0;
                o_rvalid <= 1'b1;
                o_rdata <= rd_word;
                o_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
                o_arready <= 1'b1;
            end
        end
    end

    // ***************************************************************
    // Assertions
    // ***************************************************************
    chk_shift_keeps_addr: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        disp_shift |=> addr_cnt == $past(addr_cnt))
        else $error("display shift changed the address counter");
    chk_cursor_right: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        cur_shift && wbyte[2] && !sel_cg && !two_row && addr_cnt < DD1_LAST
        |=> addr_cnt == 7'($past(addr_cnt) + 7'h01))
        else $error("cursor right did not add one");
    chk_line_wrap: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        do_wr && two_row && step_dir && !sel_cg && addr_cnt == DD2_L1_LAST
        |=> addr_cnt == DD2_L2_FIRST)
        else $error("two-line cursor did not move to line two");
    chk_set_cg: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        is_setcg |=> sel_cg && addr_cnt == {1'b0, $past(wbyte[5:0])})
        else $error("character address set failed");
    // Case equality: unwritten display cells reload as unknown
    chk_set_dd: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        is_setdd |=> !sel_cg ##1 dout === disp_mem[addr_cnt])
        else $error("display address set did not reload output data");
    chk_write_stale: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        do_wr && !pend_load |=> dout === $past(dout))
        else $error("write refreshed the output data register");
    chk_busy_read: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        i_enable && i_read_write && !i_register_select && bus_width
        |=> o_db_oe && o_db == {$past(busy_flag), $past(addr_cnt)})
        else $error("status read did not show busy flag and address");
    chk_blank_off: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        !screen_on |-> view_glyph == 8'h00 && !view_cursor)
        else $error("display off but view not blank");
    chk_nibble_pair: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        e_fall && !bus_width && !nib_second |-> !byte_done ##1 nib_second)
        else $error("4-bit first nibble completed a byte");
endmodule

/* File: verification/cle_host_model.sv */
// Host processor model for the parallel instruction port
module cle_host_model (
    // Clock and device data
    input wire logic i_mclk,
    input wire logic [7:0] i_db_dev,
    // Host strobes and data
    output logic o_reg_sel,
    output logic o_rw,
    output logic o_en,
    output logic [7:0] o_db
);
    timeunit 1ns;
    timeprecision 1ps;
    logic nib = 1'b0;
    // Idle bus at time zero
    initial begin
        o_reg_sel = 1'b0;
        o_rw = 1'b0;
        o_en = 1'b0;
        o_db = 8'h00;
    end
    // One strobe; an expired hold inverts the data, and a read inverts it back to the last value driven
    task automatic strobe(input logic sel, input logic rw, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge i_mclk);
        o_reg_sel <= sel;
        o_rw <= rw;
        o_db <= rw ? ~o_db : d;
        o_en <= 1'b1;
        repeat (2) @(posedge i_mclk);
        q = i_db_dev;
        o_en <= 1'b0;
        repeat (2) @(posedge i_mclk);
        o_db <= ~o_db;
    endtask
    // Whole byte; narrow bus sends upper nibble first on bits 7..4
    task automatic xfer(input logic sel, input logic rw, input logic [7:0] d,
                        output logic [7:0] q);
        logic [7:0] a;
        logic [7:0] b;
        if (nib) begin
            strobe(sel, rw, {d[7:4], 4'h0}, a);
            strobe(sel, rw, {d[3:0], 4'h0}, b);
            q = {a[7:4], b[7:4]};
        end else begin
            strobe(sel, rw, d, q);
        end
    endtask
    // Poll busy before issuing anything else
    task automatic wait_ready;
        logic [7:0] s;
        s = 8'h80;
        while (s[7]) xfer(1'b0, 1'b1, 8'h00, s);
    endtask
endmodule

/* File: verification/test_char_lcd_instruction_exec.sv */
// Self-checking testbench of the instruction executor
module test_char_lcd_instruction_exec import cle_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, arst_n = 1'b0, reg_sel, rw, en;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, hdb, ddb;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic [1:0] bresp, rresp, r;
    logic [7:0] q;
    int fail_count = 0, n_compared = 0;
    // Free-running 25 MHz clock
    always #20 mclk = ~mclk;
    cle_exec #(.BLINK_HALF_CYC(8)) cle_exec_inst (.i_mclk(mclk), .i_arst_n(arst_n),
        .i_register_select(reg_sel), .i_read_write(rw), .i_enable(en), .i_db(hdb), .o_db(ddb),
        .o_db_oe(), .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
        .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hF),
        .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid),
        .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
        .o_rdata(rdata), .o_rresp(rresp));
    cle_host_model cle_host_model_inst (.i_mclk(mclk), .i_db_dev(ddb), .o_reg_sel(reg_sel),
        .o_rw(rw),
        .o_en(en), .o_db(hdb));
    // ****************************************************************
    // Bus and compare helpers
    // ****************************************************************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, seen);
            fail_count++;
        end
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge mclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= d;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    // Instruction or data write, then wait out busy
    task automatic cmd(input logic sel, input logic [7:0] d);
        cle_host_model_inst.xfer(sel, 1'b0, d, q);
        cle_host_model_inst.wait_ready();
    endtask
    task automatic rd_data;
        cle_host_model_inst.xfer(1'b1, 1'b1, 8'h00, q);
        cle_host_model_inst.wait_ready();
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_regs;
        axi_rd(OFS_STATUS);
        chk("status reset", v, 32'h0000_5000);
        axi_rd(8'h0C);
        chk("unmapped resp", 32'(r), 32'(RESP_SLVERR));
        axi_wr(OFS_SCAN, 32'h10);
        axi_wr(OFS_STATUS, 32'hFFFF_FFFF);
        chk("ro write resp", 32'(r), 32'(RESP_OKAY));
        axi_rd(OFS_SCAN);
        chk("scan", v, 32'h10);
    endtask
    task automatic t_wrap;
        cmd(1'b0, 8'h3C);
        axi_rd(OFS_STATUS);
        chk("func set", 32'(v[16:14]), 32'h7);
        cle_host_model_inst.xfer(1'b0, 1'b0, 8'hA7, q);
        cle_host_model_inst.xfer(1'b0, 1'b1, 8'h00, q);
        chk("busy status", 32'(q), 32'hA7);
        cle_host_model_inst.wait_ready();
        cmd(1'b1, 8'h41);
        axi_rd(OFS_STATUS);
        chk("line wrap", 32'(v[6:0]), 32'h40);
    endtask
    task automatic t_shift;
        logic [13:0] exp [4] = '{14'h0027, 14'h0040, 14'h00C0, 14'h0040};
        for (int i = 0; i < 4; i++) begin
            cmd(1'b0, 8'h10 | 8'(i * 4));
            axi_rd(OFS_STATUS);
            chk("shift", 32'({v[23:17], v[6:0]}), 32'(exp[i]));
        end
    endtask
    task automatic t_view;
        cmd(1'b0, 8'hC0);
        cmd(1'b1, 8'h5A);
        axi_rd(OFS_VIEW);
        chk("blank", 32'(v[7:0]), 32'h0);
        cmd(1'b0, 8'h0F);
        axi_rd(OFS_VIEW);
        chk("row two col one", 32'(v[7:0]), 32'h5A);
        axi_wr(OFS_SCAN, 32'h11);
        axi_rd(OFS_VIEW);
        chk("cursor cell", 32'(v[8]), 32'h1);
        axi_rd(OFS_STATUS);
        chk("ctrl on", 32'(v[12:9]), 32'hF);
        cmd(1'b0, 8'h0C);
        axi_rd(OFS_STATUS);
        chk("ctrl off", 32'(v[12:9]), 32'h9);
    endtask
    task automatic t_read;
        cmd(1'b0, 8'hA6);
        cmd(1'b0, 8'h14); // address set by cursor shift
        rd_data();
        chk("shift reload", 32'(q), 32'h41);
        cmd(1'b1, 8'h77);
        rd_data();
        chk("latched read", 32'(q), 32'h5A);
    endtask
    task automatic t_entry_cg;
        cmd(1'b0, 8'h04);
        cmd(1'b0, 8'h85);
        cmd(1'b1, 8'h33);
        axi_rd(OFS_STATUS);
        chk("decrement", 32'(v[6:0]), 32'h04);
        cmd(1'b0, 8'h7F);
        cmd(1'b1, 8'h01); // no display shift follows
        axi_rd(OFS_STATUS);
        chk("cg select", 32'({v[8], v[6:0]}), 32'hBE);
    endtask
    task automatic t_nibble;
        // Switch to the narrow bus before polling, so busy reads pair up
        cle_host_model_inst.xfer(1'b0, 1'b0, 8'h2C, q);
        cle_host_model_inst.nib = 1'b1;
        cle_host_model_inst.wait_ready();
        cmd(1'b0, 8'hC5);
        cle_host_model_inst.xfer(1'b0, 1'b1, 8'h00, q);
        chk("nibble status", 32'(q), 32'h45);
    endtask
    task automatic end_of_test;
        if (fail_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Main sequence after six reset cycles
    initial begin
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        t_regs();
        t_wrap();
        t_shift();
        t_view();
        t_read();
        t_entry_cg();
        t_nibble();
        end_of_test();
    end
    // Watchdog well beyond the busy time of all instructions
    initial begin
        #3_000_000;
        fail_count++;
        end_of_test();
    end
endmodule
